/* File: strap_pn_pkg.sv */
// Purpose: Shared constants and types for the strap mode and test pattern block
// Assumes: 12-bit words, four lanes, six link cycles per word
// Notes: Overview of operation list follows
`default_nettype none

package strap_pn_pkg;

    // ************************************************************
    // Word format
    // ************************************************************
    localparam int WORD_W = 12;                        // Bits per sample word
    localparam int LANES = 4;                          // Output channels
    localparam int BUF_W = WORD_W * LANES;             // Buffered word width
    localparam logic [WORD_W-1:0] ALIGN_WORD = 12'h800;  // Strapped alignment word

    // ************************************************************
    // Pseudorandom generators
    // ************************************************************
    localparam int PN_S_W = 9;                         // Short register width
    localparam int PN_L_W = 23;                        // Long register width
    localparam logic [PN_S_W-1:0] PN_S_SEED = 9'h0df;  // Short start value
    localparam logic [PN_L_W-1:0] PN_L_SEED = 23'h29b80a;  // Long start value
    localparam int PN_S_TAP = 4;                       // Short feedback tap
    localparam int PN_L_TAP = 17;                      // Long feedback tap

    // ************************************************************
    // Link timing
    // ************************************************************
    localparam logic [2:0] LINK_CYC_PER_WORD = 3'h6;   // Two bits per link cycle
    localparam logic [2:0] LINK_LAST = 3'h5;           // Last link cycle of word
    localparam logic [2:0] FRAME_HIGH_CYC = 3'h3;      // Frame clock high cycles

    // ************************************************************
    // Strap capture
    // ************************************************************
    localparam logic [3:0] STRAP_SETTLE_CYC = 4'h8;    // Cycles after reset release

    // Pattern choice from same-clock logic
    typedef enum logic [1:0] {
        PAT_DATA,
        PAT_PN_SHORT,
        PAT_PN_LONG,
        PAT_RSVD
    } pattern_t;

endpackage

`default_nettype wire

/* File: word_buf_if.sv */
// Purpose: Carries word handshakes between the block and its crossing buffer
// Assumes: Write side on system clock, read side on link clock
// Notes: Ready and valid both ways
`timescale 1ns/1ps
`default_nettype none

interface word_buf_if;
    import strap_pn_pkg::*;
    logic wr_valid;             // Word offered
    logic wr_ready;             // Buffer has room
    logic [BUF_W-1:0] wr_data;  // Word written
    logic rd_valid;             // Word available
    logic rd_ready;             // Link takes word
    logic [BUF_W-1:0] rd_data;  // Word read

    // Buffer side
    modport buffer (input wr_valid, input wr_data, output wr_ready,
                    output rd_valid, output rd_data, input rd_ready);
    // User side
    modport user (output wr_valid, output wr_data, input wr_ready,
                  input rd_valid, input rd_data, output rd_ready);
endinterface

`default_nettype wire

/* File: word_cdc_buf.sv */
// Purpose: Two-entry dual-clock word buffer with gray pointers
// Assumes: Independent write and read clocks
// Notes: Full and empty are exact for two entries
`timescale 1ns/1ps
`default_nettype none

module word_cdc_buf
    import strap_pn_pkg::*;
(
    input wire logic clk_wr_i,       // Write clock
    input wire logic rst_wr_i,       // Write reset, async high
    input wire logic clk_rd_i,       // Read clock
    input wire logic rst_rd_i,       // Read reset, async high
    word_buf_if.buffer bus           // Handshake bundle
);

    logic [BUF_W-1:0] mem_ff [2];    // Storage
    logic [1:0] wbin_ff, nxt_wbin;   // Write pointer
    logic [1:0] rbin_ff, nxt_rbin;   // Read pointer
    logic [1:0] wg_ff, wg_s1_ff, wg_s2_ff;  // Flopped write gray, glitch-free
    logic [1:0] rg_ff, rg_s1_ff, rg_s2_ff;  // Flopped read gray, glitch-free
    logic push, pop;                 // Transfer strobes

    // Binary to gray
    function automatic logic [1:0] to_gray(input logic [1:0] b);
        return b ^ {1'b0, b[1]};
    endfunction

    // ************************************************************
    // Write side
    // ************************************************************
    // Full when gray pointers differ in both bits
    assign bus.wr_ready = (to_gray(wbin_ff) != ~rg_s2_ff);
    assign push = bus.wr_valid && bus.wr_ready;

    // Next write pointer
    always_comb begin
        nxt_wbin = push ? wbin_ff + 2'h1 : wbin_ff;
    end

    // Write pointer and sync of read pointer
    always_ff @(posedge clk_wr_i or posedge rst_wr_i) begin
        if (rst_wr_i) begin
            wbin_ff <= 2'h0;
            wg_ff <= 2'h0;
            rg_s1_ff <= 2'h0;
            rg_s2_ff <= 2'h0;
        end else begin
            wbin_ff <= nxt_wbin;
            wg_ff <= to_gray(nxt_wbin);
            rg_s1_ff <= rg_ff;
            rg_s2_ff <= rg_s1_ff;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_wr_i) begin
        if (push) begin
            mem_ff[wbin_ff[0]] <= bus.wr_data;
        end
    end

    // ************************************************************
    // Read side
    // ************************************************************
    assign bus.rd_valid = (to_gray(rbin_ff) != wg_s2_ff);
    assign bus.rd_data = mem_ff[rbin_ff[0]];
    assign pop = bus.rd_valid && bus.rd_ready;

    // Next read pointer
    always_comb begin
        nxt_rbin = pop ? rbin_ff + 2'h1 : rbin_ff;
    end

    // Read pointer and sync of write pointer
    always_ff @(posedge clk_rd_i or posedge rst_rd_i) begin
        if (rst_rd_i) begin
            rbin_ff <= 2'h0;
            rg_ff <= 2'h0;
            wg_s1_ff <= 2'h0;
            wg_s2_ff <= 2'h0;
        end else begin
            rbin_ff <= nxt_rbin;
            rg_ff <= to_gray(nxt_rbin);
            wg_s1_ff <= wg_ff;
            wg_s2_ff <= wg_s1_ff;
        end
    end

endmodule // word_cdc_buf

`default_nettype wire

/* File: strap_pn_top.sv */
// Purpose: Strap mode capture, test patterns and serial lane output
// Assumes: System clock is the sample clock; link clock runs six times faster
// Notes: Lanes carry two bits per link cycle for a DDR output cell
`timescale 1ns/1ps
`default_nettype none

module strap_pn_top
    import strap_pn_pkg::*;
(
    input wire logic clk_sys_i,                      // Sample clock, 125 MHz
    input wire logic rst_i,                          // Async reset, high
    input wire logic clk_link_i,                     // Bit clock domain
    input wire logic port_select_n_i,                // Control port select pin
    input wire logic serial_clock_or_pattern_strap_i,  // Serial clock pin or strap
    input wire logic serial_io_or_swing_strap_i,     // Serial data pin or strap
    input wire logic [1:0] pattern_i,                // Test pattern choice
    input wire logic [BUF_W-1:0] conv_data_i,        // Conversion words, lane 0 low
    input wire logic conv_valid_i,                   // Conversion word offered
    output logic conv_ready_o,                       // Word accepted this cycle
    output logic serial_clock_o,                     // Gated serial clock to port
    output logic serial_data_o,                      // Gated serial data to port
    output logic alignment_pattern_select_o,         // Strapped alignment mode
    output logic reduced_swing_select_o,             // Strapped reduced swing
    output logic [LANES-1:0] lane_rise_o,            // Bit on rising bit clock edge
    output logic [LANES-1:0] lane_fall_o,            // Bit on falling bit clock edge
    output logic frame_clock_out_o,                  // High for first half of word
    output logic bit_clock_run_o                     // Bit clock output enabled
);

    word_buf_if wb();                                // Crossing bundle

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] pin_s1_ff, pin_s2_ff;                // Two-stage sync of pins
    logic sel_n_s, sck_s, sio_s;                     // Synced levels

    // Pins pass two flops before use
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {port_select_n_i, serial_clock_or_pattern_strap_i, serial_io_or_swing_strap_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    assign sel_n_s = pin_s2_ff[2];
    assign sck_s = pin_s2_ff[1];
    assign sio_s = pin_s2_ff[0];

    // ************************************************************
    // Strap capture
    // ************************************************************
    logic [3:0] settle_ff, nxt_settle;               // Cycles since release
    logic latched_ff, nxt_latched;                   // Straps taken
    logic align_ff, nxt_align;                       // Alignment mode
    logic swing_ff, nxt_swing;                       // Reduced swing mode

    // Next strap state
    always_comb begin
        nxt_settle = settle_ff;
        nxt_latched = latched_ff;
        nxt_align = align_ff;
        nxt_swing = swing_ff;
        if (!latched_ff) begin
            if (settle_ff == STRAP_SETTLE_CYC) begin
                nxt_latched = 1'b1;
                nxt_align = sel_n_s && sck_s;
                nxt_swing = sel_n_s && sio_s;
            end else begin
                nxt_settle = settle_ff + 4'h1;
            end
        end
    end

    // Strap registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            settle_ff <= 4'h0;
            latched_ff <= 1'b0;
            align_ff <= 1'b0;
            swing_ff <= 1'b0;
        end else begin
            settle_ff <= nxt_settle;
            latched_ff <= nxt_latched;
            align_ff <= nxt_align;
            swing_ff <= nxt_swing;
        end
    end

    assign reduced_swing_select_o = swing_ff;
    assign alignment_pattern_select_o = align_ff;

    // ************************************************************
    // Serial port gating
    // ************************************************************
    logic sck_ff, nxt_sck;                           // Gated clock
    logic sio_ff, nxt_sio;                           // Gated data

    always_comb begin
        nxt_sck = sel_n_s ? 1'b0 : sck_s;
        nxt_sio = sel_n_s ? 1'b0 : sio_s;
    end

    // Gated port registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sck_ff <= 1'b0;
            sio_ff <= 1'b0;
        end else begin
            sck_ff <= nxt_sck;
            sio_ff <= nxt_sio;
        end
    end
    assign serial_clock_o = sck_ff;
    assign serial_data_o = sio_ff;

    // ************************************************************
    // Word source
    // ************************************************************
    logic [PN_S_W-1:0] pns_ff, nxt_pns;              // Short generator
    logic [PN_L_W-1:0] pnl_ff, nxt_pnl;              // Long generator
    logic [1:0] pat_last_ff, nxt_pat_last;           // Previous choice
    logic [BUF_W-1:0] word;                          // Word offered to buffer
    logic [WORD_W-1:0] pn_word;                      // One lane of test word
    logic pn_restart;                                // Choice changed

    // Twelve steps of the short generator, output MSB first
    function automatic logic [PN_S_W+WORD_W-1:0] pns_step(input logic [PN_S_W-1:0] s_in);
        logic [PN_S_W-1:0] s;
        logic [WORD_W-1:0] w;
        s = s_in;
        w = '0;
        for (int i = 0; i < WORD_W; i++) begin
            w = {w[WORD_W-2:0], s[PN_S_W-2]};
            s = {s[PN_S_W-2:0], s[PN_S_W-1] ^ s[PN_S_TAP]};
        end
        return {s, w};
    endfunction

    // Twelve steps of the long generator, inverted output
    function automatic logic [PN_L_W+WORD_W-1:0] pnl_step(input logic [PN_L_W-1:0] s_in);
        logic [PN_L_W-1:0] s;
        logic [WORD_W-1:0] w;
        s = s_in;
        w = '0;
        for (int i = 0; i < WORD_W; i++) begin
            w = {w[WORD_W-2:0], ~s[PN_L_W-2]};
            s = {s[PN_L_W-2:0], s[PN_L_W-1] ^ s[PN_L_TAP]};
        end
        return {s, w};
    endfunction

    assign pn_restart = (pattern_i != pat_last_ff);

    // Select word and next generator state
    always_comb begin
        logic [PN_S_W+WORD_W-1:0] rs;
        logic [PN_L_W+WORD_W-1:0] rl;
        rs = pns_step(pns_ff);
        rl = pnl_step(pnl_ff);
        nxt_pns = pns_ff;
        nxt_pnl = pnl_ff;
        nxt_pat_last = pattern_i;
        pn_word = '0;
        word = conv_data_i;
        case (pattern_t'(pattern_i))
            PAT_PN_SHORT: begin
                pn_word = rs[WORD_W-1:0];
                if (wb.wr_ready) begin
                    nxt_pns = rs[PN_S_W+WORD_W-1:WORD_W];
                end
            end
            PAT_PN_LONG: begin
                pn_word = rl[WORD_W-1:0];
                if (wb.wr_ready) begin
                    nxt_pnl = rl[PN_L_W+WORD_W-1:WORD_W];
                end
            end
            default: begin
                pn_word = '0;
            end
        endcase
        if (pattern_i == PAT_PN_SHORT || pattern_i == PAT_PN_LONG) begin
            word = {LANES{pn_word}};
        end
        if (align_ff) begin
            word = {LANES{ALIGN_WORD}};
        end
        if (pn_restart) begin
            nxt_pns = PN_S_SEED;
            nxt_pnl = PN_L_SEED;
        end
    end

    // Generator registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pns_ff <= PN_S_SEED;
            pnl_ff <= PN_L_SEED;
            pat_last_ff <= 2'h0;
        end else begin
            pns_ff <= nxt_pns;
            pnl_ff <= nxt_pnl;
            pat_last_ff <= nxt_pat_last;
        end
    end

    // Generated words need no upstream valid
    logic gen_mode;                                  // Block makes its own words
    assign gen_mode = align_ff || (pattern_i == PAT_PN_SHORT) || (pattern_i == PAT_PN_LONG);
    assign wb.wr_valid = latched_ff && !pn_restart && (gen_mode || conv_valid_i);
    assign wb.wr_data = word;
    assign conv_ready_o = latched_ff && !pn_restart && !gen_mode && wb.wr_ready;

    // ************************************************************
    // Crossing buffer
    // ************************************************************
    logic lrst_s1_ff, lrst_s2_ff;                    // Link reset sync

    // Reset asserts at once, releases on link clock
    always_ff @(posedge clk_link_i or posedge rst_i) begin
        if (rst_i) begin
            lrst_s1_ff <= 1'b1;
            lrst_s2_ff <= 1'b1;
        end else begin
            lrst_s1_ff <= 1'b0;
            lrst_s2_ff <= lrst_s1_ff;
        end
    end

    word_cdc_buf u_buf (
        .clk_wr_i(clk_sys_i),
        .rst_wr_i(rst_i),
        .clk_rd_i(clk_link_i),
        .rst_rd_i(lrst_s2_ff),
        .bus(wb.buffer)
    );

    // ************************************************************
    // Link serialiser
    // ************************************************************
    logic [2:0] phase_ff, nxt_phase;                 // Link cycle in word
    logic [BUF_W-1:0] shreg_ff, nxt_shreg;           // Lane shift words
    logic [LANES-1:0] rise_ff, nxt_rise;             // Rising edge bits
    logic [LANES-1:0] fall_ff, nxt_fall;             // Falling edge bits
    logic frame_ff, nxt_frame;                       // Frame clock level
    logic run_ff, nxt_run;                           // Clock output running

    assign wb.rd_ready = (phase_ff == LINK_LAST);

    // Next serialiser state
    always_comb begin
        nxt_phase = (phase_ff == LINK_LAST) ? 3'h0 : phase_ff + 3'h1;
        nxt_run = 1'b1;
        nxt_shreg = shreg_ff;
        for (int l = 0; l < LANES; l++) begin
            nxt_rise[l] = shreg_ff[l*WORD_W + WORD_W - 1];
            nxt_fall[l] = shreg_ff[l*WORD_W + WORD_W - 2];
            nxt_shreg[l*WORD_W +: WORD_W] = {shreg_ff[l*WORD_W +: WORD_W-2], 2'b00};
        end
        if (phase_ff == LINK_LAST) begin
            nxt_shreg = wb.rd_valid ? wb.rd_data : '0;
        end
        nxt_frame = (phase_ff < FRAME_HIGH_CYC);
    end

    // Serialiser registers
    always_ff @(posedge clk_link_i or posedge lrst_s2_ff) begin
        if (lrst_s2_ff) begin
            phase_ff <= LINK_LAST;
            shreg_ff <= '0;
            rise_ff <= '0;
            fall_ff <= '0;
            frame_ff <= 1'b0;
            run_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            shreg_ff <= nxt_shreg;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            frame_ff <= nxt_frame;
            run_ff <= nxt_run;
        end
    end

    assign lane_rise_o = rise_ff;
    assign lane_fall_o = fall_ff;
    assign frame_clock_out_o = frame_ff;
    assign bit_clock_run_o = run_ff;

endmodule // strap_pn_top

`default_nettype wire

/* File: strap_pn_top_assertions.sv */
// Purpose: Port checks for strap modes, gating and lane framing
// Assumes: Bound to every strap_pn_top instance
// Notes: Link checks run on the link clock
`timescale 1ns/1ps
`default_nettype none

module strap_pn_top_assertions
    import strap_pn_pkg::*;
(
    input wire logic clk_sys_i,                   // Sample clock
    input wire logic rst_i,                       // Async reset
    input wire logic clk_link_i,                  // Link clock
    input wire logic port_select_n_i,             // Port select pin
    input wire logic [1:0] pattern_i,             // Pattern choice
    input wire logic conv_ready_o,                // Word accepted
    input wire logic serial_clock_o,              // Gated serial clock
    input wire logic serial_data_o,               // Gated serial data
    input wire logic alignment_pattern_select_o,  // Alignment mode
    input wire logic reduced_swing_select_o,      // Reduced swing mode
    input wire logic [LANES-1:0] lane_rise_o,     // Rising edge bits
    input wire logic [LANES-1:0] lane_fall_o,     // Falling edge bits
    input wire logic frame_clock_out_o,           // Frame clock
    input wire logic bit_clock_run_o              // Bit clock enabled
);
    // ************************************************************
    // Sequences and checks
    // ************************************************************
    sequence frame_high_s;
        frame_clock_out_o [*3];
    endsequence
    sequence frame_low_s;
        !frame_clock_out_o [*3];
    endsequence
    sequence quiet_pairs_s;
        (lane_rise_o == 4'h0 && lane_fall_o == 4'h0) [*5];
    endsequence

    chk_ready_align: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        alignment_pattern_select_o |-> !conv_ready_o) else $error("ready high in alignment mode");
    chk_ready_pattern: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (pattern_i == 2'h1 || pattern_i == 2'h2 || $changed(pattern_i)) |-> !conv_ready_o)
        else $error("ready high in pattern mode");
    chk_serial_gated: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        port_select_n_i [*4] |-> serial_clock_o == 1'b0 && serial_data_o == 1'b0)
        else $error("serial pins passed while select high");
    chk_align_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        alignment_pattern_select_o |=> $stable(alignment_pattern_select_o)) else $error("alignment mode dropped");
    chk_swing_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        reduced_swing_select_o |=> reduced_swing_select_o) else $error("swing mode dropped");
    chk_frame_period: assert property (@(posedge clk_link_i) disable iff (rst_i)
        $rose(frame_clock_out_o) |-> frame_high_s ##1 frame_low_s ##1 frame_clock_out_o)
        else $error("frame clock period wrong");
    chk_align_lanes: assert property (@(posedge clk_link_i) disable iff (rst_i)
        alignment_pattern_select_o && $rose(frame_clock_out_o) |-> lane_fall_o == 4'h0
        && (lane_rise_o == 4'hf || lane_rise_o == 4'h0) ##1 quiet_pairs_s) else $error("alignment word wrong");
    chk_clock_run: assert property (@(posedge clk_link_i) disable iff (rst_i)
        bit_clock_run_o |=> bit_clock_run_o) else $error("bit clock stopped");
endmodule // strap_pn_top_assertions

bind strap_pn_top strap_pn_top_assertions u_strap_pn_top_assertions (.clk_sys_i, .rst_i, .clk_link_i,
    .port_select_n_i, .pattern_i, .conv_ready_o, .serial_clock_o, .serial_data_o, .alignment_pattern_select_o,
    .reduced_swing_select_o, .lane_rise_o, .lane_fall_o, .frame_clock_out_o, .bit_clock_run_o);

`default_nettype wire

/* File: lane_rx_model.sv */
// Purpose: Receiver that captures serial lanes into words
// Assumes: Rise bit is the earlier bit of each pair
// Notes: All-zero filler words are not queued
`timescale 1ns/1ps
`default_nettype none

module lane_rx_model
    import strap_pn_pkg::*;
(
    input wire logic clk_link_i,               // Bit clock
    input wire logic [LANES-1:0] lane_rise_i,  // Rising edge bits
    input wire logic [LANES-1:0] lane_fall_i,  // Falling edge bits
    input wire logic frame_i                   // Frame clock
);
    logic [BUF_W-1:0] words[$];  // Words seen
    logic [BUF_W-1:0] acc = '0;  // Word being built
    logic prev_frame = 1'b0;     // Frame one cycle ago
    int cnt = 0;                 // Pairs collected
    // ************************************************************
    // Capture
    // ************************************************************
    // frame rise starts word
    always @(posedge clk_link_i) begin
        if (frame_i && !prev_frame) begin
            cnt = 0;
        end
        for (int l = 0; l < LANES; l++) begin
            acc[WORD_W*l +: WORD_W] = {acc[WORD_W*l +: WORD_W-2], lane_rise_i[l], lane_fall_i[l]};
        end
        cnt = cnt + 1;
        if (cnt == 6 && acc != '0) begin
            words.push_back(acc);
        end
        prev_frame = frame_i;
    end
endmodule // lane_rx_model

`default_nettype wire

/* File: strap_pn_top_tb.sv */
// Purpose: Self-checking bench for strap modes and test patterns
// Assumes: Straps taken nine sample cycles after reset release
// Notes: Each strap setting gets its own reset
`timescale 1ns/1ps
`default_nettype none

module strap_pn_top_tb;
    import strap_pn_pkg::*;
    logic clk_sys_i = 1'b0;  // Sample clock
    logic clk_link_i = 1'b0; // Link clock
    logic rst_i = 1'b1;      // Reset
    logic sel_n = 1'b1;      // Port select pin
    logic ps = 1'b0;         // Pattern strap pin
    logic sw = 1'b0;         // Swing strap pin
    logic [1:0] pattern_i = 2'h0;
    logic [BUF_W-1:0] conv_data_i = '0;
    logic conv_valid_i = 1'b0;
    logic conv_ready_o, sclk_o, sdat_o, align_o, swing_o, frame_o, run_o;
    logic [LANES-1:0] rise_o, fall_o;
    int num_errors = 0;
    int n_checks = 0;
    logic [BUF_W-1:0] dw [4] = '{48'hc30_70a_2b5_94f, 48'h1e2_d4c_a97_36b, 48'h5f1_08e_c3d_7a2, 48'hb9c_e65_417_2d8};

    strap_pn_top u_strap_pn_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i),
        .port_select_n_i(sel_n), .serial_clock_or_pattern_strap_i(ps), .serial_io_or_swing_strap_i(sw),
        .pattern_i(pattern_i), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
        .conv_ready_o(conv_ready_o), .serial_clock_o(sclk_o), .serial_data_o(sdat_o),
        .alignment_pattern_select_o(align_o), .reduced_swing_select_o(swing_o), .lane_rise_o(rise_o),
        .lane_fall_o(fall_o), .frame_clock_out_o(frame_o), .bit_clock_run_o(run_o));
    lane_rx_model u_lane_rx_model (.clk_link_i(clk_link_i), .lane_rise_i(rise_o), .lane_fall_i(fall_o),
        .frame_i(frame_o));

    // ************************************************************
    // Clocks and shared tasks
    // ************************************************************
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #3;
        forever #6 clk_link_i = ~clk_link_i;
    end
    task automatic cmp(input logic [BUF_W-1:0] got, input logic [BUF_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset with pin levels, then check latched modes
    task automatic do_reset(input logic s, p, w, al, rs);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        sel_n <= s;
        ps <= p;
        sw <= w;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (14) @(posedge clk_sys_i);
        #1;
        cmp({run_o, align_o}, {1'b1, al});
        cmp(swing_o, rs);
        u_lane_rx_model.words.delete();
        @(posedge clk_sys_i);
    endtask
    // Offer a word and hold it until taken
    task automatic send_word(input logic [BUF_W-1:0] w, inout logic stalled);
        logic ok;
        ok = 1'b0;
        conv_data_i <= w;
        conv_valid_i <= 1'b1;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(negedge clk_sys_i);
            ok = conv_ready_o;
            stalled = stalled | !ok;
            @(posedge clk_sys_i);
        end
    endtask
    task automatic wait_words(input int n);
        for (int i = 0; i < n * 12 + 400 && u_lane_rx_model.words.size() < n; i++) @(posedge clk_sys_i);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_data(input int n);
        logic st;
        st = 1'b0;
        for (int i = 0; i < n; i++) send_word(dw[i], st);
        conv_valid_i <= 1'b0;
        if (n == 4) cmp(st, 1'b1);
        wait_words(n);
        for (int i = 0; i < n; i++) cmp(u_lane_rx_model.words[i], dw[i]);
    endtask
    task automatic test_serial;
        for (int i = 0; i < 8; i++) begin
            ps <= i[0];
            sw <= i[1];
            @(negedge clk_sys_i);
            cmp({sclk_o, sdat_o, align_o, swing_o}, 4'h0);
            @(posedge clk_sys_i);
        end
        ps <= 1'b0;
        sw <= 1'b0;
    endtask
    task automatic test_pn(input logic [1:0] p, input logic [WORD_W-1:0] e0, e1, e2, input int n);
        u_lane_rx_model.words.delete();
        pattern_i <= p;
        wait_words(n);
        cmp(u_lane_rx_model.words[0], {LANES{e0}});
        cmp(u_lane_rx_model.words[1], {LANES{e1}});
        cmp(u_lane_rx_model.words[2], {LANES{e2}});
        if (n > 3) cmp(u_lane_rx_model.words[511], u_lane_rx_model.words[0]);
        if (n > 3) cmp(u_lane_rx_model.words[513], u_lane_rx_model.words[2]);
        pattern_i <= 2'h0;
        repeat (60) @(posedge clk_sys_i);
        u_lane_rx_model.words.delete();
    endtask
    task automatic test_align;
        conv_valid_i <= 1'b1;
        wait_words(3);
        @(negedge clk_sys_i);
        cmp(conv_ready_o, 1'b0);
        for (int i = 0; i < 3; i++) cmp(u_lane_rx_model.words[i], {LANES{12'h800}});
        @(posedge clk_sys_i);
        conv_valid_i <= 1'b0;
        ps <= 1'b0;
        sw <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        #1;
        cmp({align_o, swing_o}, 2'h3);
        @(posedge clk_sys_i);
    endtask
    task automatic test_port;
        repeat (5) @(posedge clk_sys_i);
        #1;
        cmp({sclk_o, sdat_o}, 2'h2);
        @(posedge clk_sys_i);
    endtask

    initial begin
        do_reset(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        test_data(4);
        test_serial;
        test_pn(2'h1, 12'hdf9, 12'h353, 12'h301, 514);
        test_pn(2'h2, 12'h591, 12'hfd7, 12'h0a3, 3);
        do_reset(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        test_align;
        do_reset(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        test_data(2);
        do_reset(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        test_port;
        tally_and_finish;
    end
    initial begin
        #300000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish;
    end
endmodule // strap_pn_top_tb

`default_nettype wire
